// file: core/refmon_pkg.sv
// Shared constants and carrier types for the reference clock monitor
package refmon_pkg;
   localparam int NUM_REFS = 2;
   localparam int CNT_W = 24;
   localparam int PPM_W = 16;
   localparam int SLEW_W = 24;
   // Crystal range limits in kHz
   localparam int XTAL_MIN_KHZ = 9000;
   localparam int XTAL_MAX_KHZ = 160000;
   localparam int CLK_KHZ = 20000;
   // Crystal gate window: 1 ms of the system clock
   localparam int XTAL_GATE_US = 1000;
   localparam int XTAL_GATE_CYC = CLK_KHZ * XTAL_GATE_US / 1000;
   localparam int XTAL_MIN_CNT = XTAL_MIN_KHZ * XTAL_GATE_US / 1000;
   localparam int XTAL_MAX_CNT = XTAL_MAX_KHZ * XTAL_GATE_US / 1000;
   // Reset values of status
   localparam logic FLAG_RESET = 1'b1;

   // Per-reference monitor configuration
   typedef struct packed {
      logic freq_en;
      logic late_en;
      logic early_en;
      logic pps_en;
      logic valid_en;
      logic [CNT_W-1:0] nominal;
      logic [CNT_W-1:0] late_win;
      logic [CNT_W-1:0] early_win;
      logic [CNT_W-1:0] jitter_margin;
      logic [CNT_W-1:0] valid_time;
      logic [CNT_W-1:0] freq_gate;
      logic [PPM_W-1:0] ppm_valid;
      logic [PPM_W-1:0] ppm_invalid;
   } ref_cfg_t;

   // Per-reference monitor flags
   typedef struct packed {
      logic freq_fault;
      logic window_fault;
      logic pps_fault;
      logic qualified;
   } ref_stat_t;

   // Phase slew configuration
   typedef struct packed {
      logic enable;
      logic [SLEW_W-1:0] step_limit;
      logic [SLEW_W-1:0] timer;
   } slew_cfg_t;
endpackage

// file: core/ref_channel.sv
// One reference input: frequency, window, 1-PPS monitors and validation
`timescale 1ns/100ps
module ref_channel
   import refmon_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic edge_in,
   input wire ref_cfg_t cfg_in,
   output ref_stat_t stat_out
);
   typedef enum logic [1:0] {MEAS, EVAL} fstate_t;
   logic freq_on, late_on, early_on, pps_on;
   logic [CNT_W-1:0] period, next_period;
   logic [CNT_W-1:0] gate, next_gate;
   logic [CNT_W-1:0] edges, next_edges;
   logic [CNT_W-1:0] vtime, next_vtime;
   logic [CNT_W-1:0] err;
   logic late_f, next_late_f, early_f, next_early_f;
   logic pps_f, next_pps_f, freq_f, next_freq_f;
   logic qual, next_qual, any_flag;
   fstate_t fst, next_fst;

   // Exclusive monitor enables; early needs late; PPS disables others
   assign pps_on = cfg_in.pps_en;
   assign freq_on = cfg_in.freq_en & ~pps_on;
   assign late_on = cfg_in.late_en & ~pps_on;
   assign early_on = cfg_in.early_en & late_on;
   assign any_flag = (freq_on & freq_f) | (late_on & late_f)
      | (early_on & early_f) | (pps_on & pps_f);

   // Ppm error of counted edges against expected count (unscaled absolute difference)
   always_comb begin
      if (edges > cfg_in.nominal)
         err = edges - cfg_in.nominal;
      else
         err = cfg_in.nominal - edges;
   end

   // Window detectors, ppm detector and validation timer
   always_comb begin
      next_period = period + 1'b1;
      next_late_f = late_f;
      next_early_f = early_f;
      next_pps_f = pps_f;
      next_freq_f = freq_f;
      next_gate = gate + 1'b1;
      next_edges = edges + {{(CNT_W-1){1'b0}}, edge_in};
      next_fst = fst;
      next_vtime = vtime;
      next_qual = qual;
      if (edge_in) begin
         next_period = '0;
         if (period < cfg_in.nominal - cfg_in.early_win)
            next_early_f = 1'b1;
         else
            next_early_f = 1'b0;
         // A gap inside the late window keeps a gapped input locked
         next_late_f = 1'b0;
         next_pps_f = 1'b0;
      end else begin
         if (period >= cfg_in.nominal + cfg_in.late_win)
            next_late_f = 1'b1;
         if (period >= cfg_in.nominal + cfg_in.jitter_margin)
            next_pps_f = 1'b1;
      end
      if (!late_on) next_late_f = 1'b0;
      if (!early_on) next_early_f = 1'b0;
      if (!pps_on) next_pps_f = 1'b0;
      // Gate length sets accuracy and averaging, hence delay
      case (fst)
         MEAS: begin
            if (gate >= cfg_in.freq_gate) next_fst = EVAL;
         end
         EVAL: begin
            if (err < cfg_in.ppm_valid) next_freq_f = 1'b0;
            else if (err > cfg_in.ppm_invalid) next_freq_f = 1'b1;
            next_gate = '0;
            next_edges = '0;
            next_fst = MEAS;
         end
         default: next_fst = MEAS;
      endcase
      if (!freq_on) next_freq_f = 1'b0;
      // Qualification only after flag-free validation time
      if (any_flag) begin
         next_vtime = '0;
         next_qual = 1'b0;
      end else if (!cfg_in.valid_en || vtime >= cfg_in.valid_time) begin
         next_qual = 1'b1;
      end else begin
         next_vtime = vtime + 1'b1;
      end
   end

   // State registers, all flags but the early flag set at reset
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         period <= '0;
         gate <= '0;
         edges <= '0;
         vtime <= '0;
         fst <= MEAS;
         late_f <= FLAG_RESET;
         early_f <= 1'b0;
         pps_f <= FLAG_RESET;
         freq_f <= FLAG_RESET;
         qual <= 1'b0;
      end else begin
         period <= next_period;
         gate <= next_gate;
         edges <= next_edges;
         vtime <= next_vtime;
         fst <= next_fst;
         late_f <= next_late_f;
         early_f <= next_early_f;
         pps_f <= next_pps_f;
         freq_f <= next_freq_f;
         qual <= next_qual;
      end
   end

   assign stat_out.freq_fault = freq_f;
   assign stat_out.window_fault = late_f | early_f;
   assign stat_out.pps_fault = pps_f;
   assign stat_out.qualified = qual;

   // Late pulse must raise window flag within a cycle
   late_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
      late_on && !edge_in && period >= cfg_in.nominal + cfg_in.late_win
      |=> late_f) else $error("late flag missed");
   pps_excl_a: assert property (@(posedge clk_in) disable iff (rst_in)
      pps_on |=> !freq_f && !late_f && !early_f)
      else $error("pps input kept other flags");
   early_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !late_on |=> !early_f) else $error("early alone");
   qual_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      any_flag |=> !qual) else $error("qualified with flag");
endmodule

// file: core/phase_slew.sv
// Phase offset removal limited in step size and step rate
`timescale 1ns/100ps
module phase_slew
   import refmon_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire slew_cfg_t cfg_in,
   input wire logic event_in,
   input wire logic cancel_en_in,
   input wire logic signed [SLEW_W-1:0] offset_in,
   output logic signed [SLEW_W-1:0] phase_out,
   output logic busy_out
);
   logic signed [SLEW_W-1:0] resid, next_resid;
   logic [SLEW_W-1:0] tick, next_tick;
   logic signed [SLEW_W-1:0] lim;

   assign lim = signed'(cfg_in.step_limit);

   // Residual offset removed by at most one step per timer period
   always_comb begin
      next_resid = resid;
      next_tick = tick + 1'b1;
      if (event_in) begin
         if (cfg_in.enable || cancel_en_in)
            next_resid = offset_in;
         else
            next_resid = '0;
         next_tick = '0;
      end else if (cfg_in.enable && tick >= cfg_in.timer) begin
         next_tick = '0;
         if (resid > lim) next_resid = resid - lim;
         else if (resid < -lim) next_resid = resid + lim;
         else next_resid = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         resid <= '0;
         tick <= '0;
      end else begin
         resid <= next_resid;
         tick <= next_tick;
      end
   end

   // Output phase held back by residual build-out
   always_ff @(posedge clk_in) begin
      if (rst_in) phase_out <= '0;
      else phase_out <= resid;
   end
   assign busy_out = (resid != '0);

   step_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_in.enable && !event_in && resid > lim |=>
      resid == $past(resid) || resid == $past(resid) - lim)
      else $error("slew step too large");
endmodule

// file: core/refclk_monitor.sv
// Overview of operation
// - Phase slew limits output transient on switching and holdover exit.
// - Build-out offset removed gradually by step limit per timer period.
// - Slew also applies on lock acquisition and unlocked-input switching.
// - Without cancellation or slew, switching offset passes straight through.
// - Gapped input yields gapless output at its average frequency.
// - Ppm detector and phase-valid monitor never both enabled.
// - Crystal loss flag clear only between 9 and 160 MHz.
// - Bypass makes the crystal always valid for PLL control.
// - Bypass leaves the crystal loss flag untouched.
// - Monitors independent per input; 1-PPS uses phase-valid only.
// - Qualified only after flag-free validation time.
// - Disabled monitors raise no flag and are ignored.
// - Pins show all inputs; status shows the selected input only.
// - Ppm flag clears below valid, sets above invalid, else holds.
// - Finer accuracy or more averaging lengthens measurement delay.
// - Late detector flags when no pulse by nominal plus late window.
// - Late and early share a detector; flags ORed.
// - Early detector flags pulses before nominal minus early window.
// - Early detection works only with late detection enabled.
// - 1-PPS pulse late past nominal plus jitter margin flags at once.
`timescale 1ns/100ps
module refclk_monitor
   import refmon_pkg::*;
#(
   parameter int REFS = NUM_REFS
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic crystal_input_in,
   input wire logic [REFS-1:0] ref_clk_in,
   input wire ref_cfg_t [REFS-1:0] ref_cfg_in,
   input wire logic crystal_detector_bypass_in,
   input wire logic [$clog2(REFS+1)-1:0] selected_ref_in,
   input wire slew_cfg_t slew_cfg_in,
   input wire logic phase_cancel_en_in,
   input wire logic switch_event_in,
   input wire logic signed [SLEW_W-1:0] switch_offset_in,
   output ref_stat_t [REFS-1:0] ref_pin_stat_out,
   output logic [REFS-1:0] ref_qualified_out,
   output logic reference_freq_fault_flag_out,
   output logic reference_window_fault_flag_out,
   output logic crystal_freq_loss_flag_out,
   output logic crystal_valid_out,
   output logic signed [SLEW_W-1:0] slew_phase_out,
   output logic slew_busy_out
);
   typedef enum logic [1:0] {GATE, JUDGE} xstate_t;
   logic [REFS-1:0] ref_s1, ref_s2, ref_s3;
   logic xo_s1, xo_s2, xo_s3;
   logic [REFS-1:0] ref_edge;
   logic xo_edge;
   logic [31:0] xgate, next_xgate;
   logic [31:0] xcount, next_xcount;
   logic xloss, next_xloss;
   xstate_t xst, next_xst;
   ref_stat_t [REFS-1:0] stat;
   ref_stat_t sel_stat;

   // Elaboration check on the number of inputs
   if (REFS < 1 || REFS > 8) begin : g_bad_refs
      $error("REFS out of range");
   end

   // Two-stage synchronisers then edge detect on later stages
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_s1 <= '0;
         ref_s2 <= '0;
         ref_s3 <= '0;
         xo_s1 <= 1'b0;
         xo_s2 <= 1'b0;
         xo_s3 <= 1'b0;
      end else begin
         ref_s1 <= ref_clk_in;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         xo_s1 <= crystal_input_in;
         xo_s2 <= xo_s1;
         xo_s3 <= xo_s2;
      end
   end
   assign ref_edge = ref_s2 & ~ref_s3;
   assign xo_edge = xo_s2 & ~xo_s3;

   // Independent monitor set per reference input
   generate
      for (genvar i = 0; i < REFS; i++) begin : g_ref
         ref_channel u_ch (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .edge_in(ref_edge[i]),
            .cfg_in(ref_cfg_in[i]),
            .stat_out(stat[i])
         );
         assign ref_qualified_out[i] = stat[i].qualified;
      end
   endgenerate

   // Pins carry every input's flags
   assign ref_pin_stat_out = stat;

   // Status bits follow the selected input only
   always_comb begin
      sel_stat = '{freq_fault: 1'b1, window_fault: 1'b1,
         pps_fault: 1'b1, qualified: 1'b0};
      for (int k = 0; k < REFS; k++) begin
         if (int'(selected_ref_in) == k)
            sel_stat = stat[k];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reference_freq_fault_flag_out <= FLAG_RESET;
         reference_window_fault_flag_out <= FLAG_RESET;
      end else begin
         reference_freq_fault_flag_out <= sel_stat.freq_fault;
         reference_window_fault_flag_out <= sel_stat.window_fault;
      end
   end

   // Crystal coarse frequency detector over a fixed gate
   always_comb begin
      next_xgate = xgate + 32'h1;
      next_xcount = xcount + {31'h0, xo_edge};
      next_xloss = xloss;
      next_xst = xst;
      case (xst)
         GATE: begin
            if (xgate >= XTAL_GATE_CYC - 1) next_xst = JUDGE;
         end
         JUDGE: begin
            if (xcount >= XTAL_MIN_CNT && xcount <= XTAL_MAX_CNT)
               next_xloss = 1'b0;
            else
               next_xloss = 1'b1;
            next_xgate = '0;
            next_xcount = '0;
            next_xst = GATE;
         end
         default: next_xst = GATE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         xgate <= '0;
         xcount <= '0;
         xloss <= FLAG_RESET;
         xst <= GATE;
      end else begin
         xgate <= next_xgate;
         xcount <= next_xcount;
         xloss <= next_xloss;
         xst <= next_xst;
      end
   end

   // Loss flag is the detector's own; bypass only forces validity
   assign crystal_freq_loss_flag_out = xloss;
   assign crystal_valid_out = crystal_detector_bypass_in | ~xloss;

   // Slew on switchover, holdover exit and lock acquisition events
   phase_slew u_slew (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg_in(slew_cfg_in),
      .event_in(switch_event_in),
      .cancel_en_in(phase_cancel_en_in),
      .offset_in(switch_offset_in),
      .phase_out(slew_phase_out),
      .busy_out(slew_busy_out)
   );

   bypass_valid_a: assert property (@(posedge clk_in) disable iff (rst_in)
      crystal_detector_bypass_in |-> crystal_valid_out)
      else $error("bypass not valid");
   xo_judge_a: assert property (@(posedge clk_in) disable iff (rst_in)
      xst == JUDGE && xcount > XTAL_MAX_CNT |=> xloss)
      else $error("crystal over range not flagged");
   xo_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      xst == GATE |=> xloss == $past(xloss))
      else $error("crystal flag moved mid gate");
   sel_stat_a: assert property (@(posedge clk_in) disable iff (rst_in)
      selected_ref_in == 0 |=>
      reference_window_fault_flag_out == $past(stat[0].window_fault))
      else $error("status not of selected input");
endmodule

// file: testbench/ref_source_model.sv
// Behavioural crystal oscillator and reference clock sources
`timescale 1ns/100ps
module ref_source_model
#(
   parameter int REFS = 2
)
(
   input wire logic clk_in,
   input wire logic [15:0] xtal_half_in,
   input wire logic [REFS-1:0][7:0] period_in,
   output logic crystal_out,
   output logic [REFS-1:0] ref_out
);
   logic [REFS-1:0][7:0] count = '0;
   // Crystal toggles every half period in 100 ps units; zero stands still
   initial begin
      crystal_out = 1'b0;
      forever begin
         if (xtal_half_in == 16'h0000) begin
            crystal_out = 1'b0;
            #10;
         end else begin
            #(xtal_half_in * 0.1);
            crystal_out = ~crystal_out;
         end
      end
   end
   // High for the first half of each period; zero period is a gap
   always @(posedge clk_in) begin
      for (int i = 0; i < REFS; i++) begin
         if (period_in[i] == 8'h00 || count[i] >= period_in[i] - 8'h01) begin
            count[i] <= 8'h00;
         end else begin
            count[i] <= count[i] + 8'h01;
         end
         ref_out[i] <= period_in[i] != 8'h00 && count[i] < period_in[i] / 2;
      end
   end
endmodule

// file: testbench/refclk_monitor_bench.sv
// Self-checking bench for the reference clock monitor
`timescale 1ns/100ps
module refclk_monitor_bench;
   import refmon_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [15:0] xtal_half;
   logic [1:0][7:0] period;
   logic crystal, bypass, cancel, event_p, ffault, wfault, loss, xvalid, busy;
   logic [1:0] refs, sel, qual;
   ref_cfg_t [1:0] cfg;
   slew_cfg_t scfg;
   logic signed [SLEW_W-1:0] offset, phase;
   ref_stat_t [1:0] pin;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   refclk_monitor #(.REFS(2)) DUT (.clk_in(clk_in), .rst_in(rst_in),
      .crystal_input_in(crystal), .ref_clk_in(refs), .ref_cfg_in(cfg),
      .crystal_detector_bypass_in(bypass), .selected_ref_in(sel),
      .slew_cfg_in(scfg), .phase_cancel_en_in(cancel),
      .switch_event_in(event_p), .switch_offset_in(offset),
      .ref_pin_stat_out(pin), .ref_qualified_out(qual),
      .reference_freq_fault_flag_out(ffault),
      .reference_window_fault_flag_out(wfault),
      .crystal_freq_loss_flag_out(loss), .crystal_valid_out(xvalid),
      .slew_phase_out(phase), .slew_busy_out(busy));
   ref_source_model #(.REFS(2)) source (.clk_in(clk_in),
      .xtal_half_in(xtal_half), .period_in(period), .crystal_out(crystal),
      .ref_out(refs));

   // Clock and hang guard
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 95000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      #1;
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Enables are freq, late, early, pps, valid; nominal 20, windows 4
   task automatic setup(input int i, input logic [4:0] en,
      input logic [7:0] per);
      cyc(1);
      cfg[i] <= '{en[4], en[3], en[2], en[1], en[0], 24'h000014, 24'h000004,
         24'h000004, 24'h000004, 24'h000064, 24'h000190, 16'h0003, 16'h0006};
      period[i] <= per;
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Late and early windows, validation timer, selected status
   task automatic window_test();
      setup(0, 5'b01101, 8'h14);
      cyc(80);
      chk(qual[0], 0);
      cyc(170);
      chk({pin[0].window_fault, qual[0], wfault}, 3'b010);
      cyc(1);
      period[0] <= 8'h00;
      cyc(35);
      chk({pin[0].window_fault, qual[0], wfault}, 3'b101);
      cyc(1);
      sel <= 2'd1;
      cyc(3);
      chk(wfault, 0);
      cyc(1);
      sel <= 2'd2;
      cyc(3);
      chk({wfault, ffault}, 2'b11);
      cyc(1);
      sel <= 2'd0;
      setup(0, 5'b01101, 8'h14);
      cyc(100);
      period[0] <= 8'h0A;
      cyc(40);
      chk(pin[0].window_fault, 1);
      setup(0, 5'b00101, 8'h0A);
      cyc(60);
      chk(pin[0].window_fault, 0);
   endtask

   // Ppm detector with hysteresis between thresholds
   task automatic freq_test();
      logic [7:0] pers [5] = '{8'h14, 8'h18, 8'h28, 8'h18, 8'h14};
      logic [4:0] flag = 5'b00110;
      setup(1, 5'b10000, 8'h14);
      for (int k = 0; k < 5; k++) begin
         cyc(1);
         period[1] <= pers[k];
         cyc(900);
         chk({pin[1].freq_fault, qual[1]}, {flag[4-k], ~flag[4-k]});
      end
      cyc(1);
      sel <= 2'd1;
      cyc(3);
      chk(ffault, 0);
      cyc(1);
      sel <= 2'd0;
   endtask

   // One-pulse-per-second monitor overrides the other monitors
   task automatic pps_test();
      setup(1, 5'b11010, 8'h14);
      cyc(200);
      chk({pin[1].pps_fault, pin[1].freq_fault,
         pin[1].window_fault}, 0);
      cyc(1);
      period[1] <= 8'h00;
      cyc(35);
      chk({pin[1].pps_fault, pin[1].freq_fault,
         pin[1].window_fault}, 4);
   endtask

   // Limited slew, build-out hold and plain pass-through
   task automatic slew_test();
      logic signed [SLEW_W-1:0] prev;
      int gap;
      int steps;
      prev = '0;
      gap = 9;
      steps = 0;
      cyc(1);
      scfg <= '{1'b1, 24'h000005, 24'h000003};
      cancel <= 1'b1;
      offset <= 24'sh000017;
      event_p <= 1'b1;
      cyc(1);
      event_p <= 1'b0;
      repeat (60) begin
         cyc(1);
         #1;
         if (phase !== prev) begin
            if (prev == 0) begin
               chk(phase, 32'h00000017);
            end else begin
               chk(prev - phase <= 5 && gap >= 3, 1);
               steps++;
            end
            gap = 0;
         end else begin
            gap++;
         end
         prev = phase;
      end
      chk({phase, busy}, 0);
      chk(steps, 5);
      cyc(1);
      scfg.enable <= 1'b0;
      event_p <= 1'b1;
      cyc(1);
      event_p <= 1'b0;
      cyc(20);
      chk({phase, busy}, 32'h0000002F);
      cyc(1);
      cancel <= 1'b0;
      event_p <= 1'b1;
      cyc(1);
      event_p <= 1'b0;
      cyc(6);
      chk({phase, busy}, 0);
   endtask

   // Crystal range detector and bypass
   task automatic crystal_test();
      cyc(37000);
      chk({loss, xvalid}, 2'b01);
      cyc(1);
      xtal_half <= 16'h03E8;
      cyc(42000);
      chk({loss, xvalid}, 2'b10);
      cyc(1);
      bypass <= 1'b1;
      cyc(2);
      chk({loss, xvalid}, 2'b11);
   endtask

   // Main sequence
   initial begin
      xtal_half = 16'h020E;
      period = '0;
      bypass = 1'b0;
      cancel = 1'b0;
      event_p = 1'b0;
      sel = 2'd0;
      cfg = '0;
      scfg = '0;
      offset = '0;
      cyc(3);
      chk({pin[0].freq_fault, pin[0].window_fault, pin[1].freq_fault,
         pin[1].window_fault, qual, loss, busy}, 8'hF2);
      chk(phase, 0);
      cyc(1);
      rst_in <= 1'b0;
      window_test();
      freq_test();
      pps_test();
      slew_test();
      crystal_test();
      tally_and_finish();
   end
endmodule
